//--- verilog/pll_ctl_pkg.sv
// Package: register map, field positions, reset values and timing for the loop control block
// Contract
// - Modulo divider divides VCO clock by multiplier N into feedback clock.
// - Phase compare feedback against reference; correction pulse width and direction follow.
// - Lock detector compares frequencies per window of 16 reference periods, decides mode and lock.
// - Acquisition mode presents tracking flag as cleared.
// - Tracking mode whenever not acquiring or tracking flag set.
// - Automatic select bit 1 lets lock detector switch filter modes.
// - Automatic mode: tracking flag read-only, set within tracking, cleared outside untracking.
// - Automatic mode: settled indicator read-only, set within lock, cleared outside unlock.
// - Automatic mode with enable 1: settled toggle raises interrupt request.
// - Automatic select bit 0: tracking flag writable, selects mode directly.
// - Manual mode disables settled indicator and interrupt requests.
// - Programming register holds N in upper nibble, L in lower nibble.
// - N of zero divides as if one.
// - L of zero disables loop and forces crystal clock source.
// - Range multiplier sets centre frequency L times 4.9152 MHz nominal.
// - Change flag set per settled toggle, reads 0 in manual, clears on control read.
// - Refuse source select while power off; refuse power off while source selected.
package pll_ctl_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_LOOP_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_BANDWIDTH = 8'h04;
  localparam logic [7:0] ADDR_MULT_RANGE = 8'h08;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_IRQ_EN_BIT = 7;
  localparam int CTL_FLAG_BIT = 6;
  localparam int CTL_PWR_BIT = 5;
  localparam int CTL_SRC_BIT = 4;
  localparam int BW_AUTO_BIT = 7;
  localparam int BW_LOCK_BIT = 6;
  localparam int BW_TRACK_BIT = 5;
  localparam int BW_XLD_BIT = 4;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CTL_RESET = 8'h2F;
  localparam logic [7:0] CTL_UNUSED_ONES = 8'h0F;
  localparam logic [7:0] BW_RESET = 8'h00;
  localparam logic [7:0] MULT_RANGE_RESET = 8'h66;
  // ----------------------------------------
  // Lock detector tolerances (feedback edges per window, deviation)
  // ----------------------------------------
  localparam int DET_WINDOW_REFS = 16;
  localparam int TOL_LOCK = 1;
  localparam int TOL_UNLOCK = 2;
  localparam int TOL_TRACK = 2;
  localparam int TOL_UNTRACK = 4;
  // Nominal VCO centre in kHz (4.9152 MHz)
  localparam int F_NOM_KHZ = 4915;
  localparam int CORE_CLK_MHZ = 50;
endpackage

//--- verilog/pll_feedback_div.sv
// Modulo divider producing the VCO feedback clock enable
`timescale 1ns/1ps
module pll_feedback_div
  import pll_ctl_pkg::*;
#(
  parameter int DIV_W = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Control
  input wire logic run_i,
  input wire logic vco_tick_i,
  input wire logic [DIV_W-1:0] mult_i,
  // Feedback
  output logic fb_tick_o
);
  // Only divider widths up to a byte are supported
  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div_w
    $error("DIV_W out of range");
  end

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] top;

  assign top = (mult_i == '0) ? '0 : DIV_W'(mult_i - 1'b1);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
      fb_tick_o <= 1'b0;
    end else if (clk_en_i) begin
      fb_tick_o <= 1'b0;
      if (!run_i) begin
        cnt_q <= '0;
      end else if (vco_tick_i) begin
        if (cnt_q >= top) begin
          cnt_q <= '0;
          fb_tick_o <= 1'b1;
        end else begin
          cnt_q <= DIV_W'(cnt_q + 1'b1);
        end
      end
    end
  end
endmodule // pll_feedback_div

//--- verilog/pll_mode_lock_control.sv
// Loop mode, lock detection and register file of the clock generator
`timescale 1ns/1ps
module pll_mode_lock_control
  import pll_ctl_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock events, one-cycle strobes
  input wire logic vco_clock_i,
  input wire logic final_reference_clock_i,
  // Loop outputs
  output logic vco_feedback_clock_o,
  output logic pump_up_o,
  output logic pump_down_o,
  output logic tracking_mode_o,
  output logic loop_enable_o,
  output logic base_source_select_o,
  output logic [3:0] vco_range_o,
  output logic irq_o
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Counter must hold a full window count of feedback pulses
  if (CNT_W < $clog2(DET_WINDOW_REFS + 1) || CNT_W > 16) begin : g_bad_cnt_w
    $error("CNT_W out of range");
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic settle_change_irq_enable_q;
  logic settle_change_flag_q;
  logic loop_power_on_q;
  logic base_source_select_q;
  logic auto_q;
  logic settled_q;
  logic track_q;
  logic xld_q;
  logic [7:0] multiplier_programming_reg_q;
  logic wr_en;
  logic rd_en;
  logic loop_run;
  logic fb_tick;
  logic settle_toggle;
  logic ctl_wr;
  logic bw_wr;
  logic mult_wr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // A range field of zero means no usable VCO range
  function automatic logic range_zero(input logic [7:0] prog);
    range_zero = (prog[3:0] == 4'h0);
  endfunction

  // Only the access edge with pready high acts, so a longer access cannot act twice
  assign wr_en = clk_en_i && psel && penable && pready && pwrite;
  assign rd_en = clk_en_i && psel && penable && pready && !pwrite;
  assign ctl_wr = wr_en && hit(paddr, ADDR_LOOP_CONTROL);
  assign bw_wr = wr_en && hit(paddr, ADDR_BANDWIDTH);
  assign mult_wr = wr_en && hit(paddr, ADDR_MULT_RANGE);

  assign loop_run = loop_power_on_q && !range_zero(multiplier_programming_reg_q);

  // ----------------------------------------
  // Feedback divider
  // ----------------------------------------
  pll_feedback_div #(
    .DIV_W(4)
  ) u_div (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .run_i(loop_run),
    .vco_tick_i(vco_clock_i),
    .mult_i(multiplier_programming_reg_q[7:4]),
    .fb_tick_o(fb_tick)
  );

  // ----------------------------------------
  // Phase detector
  // ----------------------------------------
  // pulse from leading edge until lagging edge
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pump_up_o <= 1'b0;
      pump_down_o <= 1'b0;
    end else if (clk_en_i) begin
      if (!loop_run || (fb_tick && final_reference_clock_i)) begin
        pump_up_o <= 1'b0;
        pump_down_o <= 1'b0;
      end else if (final_reference_clock_i) begin
        if (pump_down_o) begin
          pump_down_o <= 1'b0;
        end else begin
          pump_up_o <= 1'b1;
        end
      end else if (fb_tick) begin
        if (pump_up_o) begin
          pump_up_o <= 1'b0;
        end else begin
          pump_down_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Lock detector
  // ----------------------------------------
  // Window of reference ticks; feedback ticks should match its length
  logic [CNT_W-1:0] ref_cnt_q;
  logic [CNT_W-1:0] fb_cnt_q;
  logic [CNT_W-1:0] dev;
  logic window_end;

  assign window_end = final_reference_clock_i && (ref_cnt_q == CNT_W'(DET_WINDOW_REFS - 1));
  assign dev = (fb_cnt_q > CNT_W'(DET_WINDOW_REFS)) ? CNT_W'(fb_cnt_q - CNT_W'(DET_WINDOW_REFS))
                                                     : CNT_W'(CNT_W'(DET_WINDOW_REFS) - fb_cnt_q);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_cnt_q <= '0;
      fb_cnt_q <= '0;
    end else if (clk_en_i) begin
      if (!loop_run) begin
        ref_cnt_q <= '0;
        fb_cnt_q <= '0;
      end else begin
        if (final_reference_clock_i) begin
          ref_cnt_q <= window_end ? '0 : CNT_W'(ref_cnt_q + 1'b1);
        end
        if (window_end) begin
          fb_cnt_q <= CNT_W'(fb_tick);
        // Saturate so a stalled reference cannot wrap the count
        end else if (fb_tick && fb_cnt_q != '1) begin
          fb_cnt_q <= CNT_W'(fb_cnt_q + 1'b1);
        end
      end
    end
  end

  // settled with hysteresis; off in manual
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settled_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!auto_q || !loop_run) begin
        settled_q <= 1'b0;
      end else if (window_end) begin
        if (dev <= CNT_W'(TOL_LOCK)) begin
          settled_q <= 1'b1;
        end else if (dev > CNT_W'(TOL_UNLOCK)) begin
          settled_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Filter mode flag
  // ----------------------------------------
  // hardware drives flag in automatic mode
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      track_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!auto_q) begin
        if (bw_wr) begin
          track_q <= pwdata[BW_TRACK_BIT];
        end
      end else if (!loop_run) begin
        // Loop off restarts in acquisition
        track_q <= 1'b0;
      end else if (window_end) begin
        if (dev <= CNT_W'(TOL_TRACK)) begin
          track_q <= 1'b1;
        end else if (dev > CNT_W'(TOL_UNTRACK)) begin
          track_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic settled_prev_q;
  logic ctl_read;

  assign settle_toggle = auto_q && (settled_q != settled_prev_q);
  assign ctl_read = rd_en && hit(paddr, ADDR_LOOP_CONTROL);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settled_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      settled_prev_q <= settled_q;
    end
  end

  // toggle sets, control read clears, set wins
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_change_flag_q <= CTL_RESET[CTL_FLAG_BIT];
    end else if (clk_en_i) begin
      if (!auto_q) begin
        settle_change_flag_q <= 1'b0;
      end else if (settle_toggle) begin
        settle_change_flag_q <= 1'b1;
      end else if (ctl_read) begin
        settle_change_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_change_irq_enable_q <= CTL_RESET[CTL_IRQ_EN_BIT];
      loop_power_on_q <= CTL_RESET[CTL_PWR_BIT];
      base_source_select_q <= CTL_RESET[CTL_SRC_BIT];
    end else if (clk_en_i) begin
      if (!auto_q) begin
        settle_change_irq_enable_q <= 1'b0;
      end else if (ctl_wr) begin
        settle_change_irq_enable_q <= pwdata[CTL_IRQ_EN_BIT];
      end
      // Refusals test the state before this write, so one write cannot power up and select
      if (ctl_wr) begin
        // power stays on while source selected
        if (pwdata[CTL_PWR_BIT] || !base_source_select_q) begin
          loop_power_on_q <= pwdata[CTL_PWR_BIT];
        end
        // select needs power already on; and nonzero range
        if (!pwdata[CTL_SRC_BIT] || (loop_power_on_q && !range_zero(multiplier_programming_reg_q))) begin
          base_source_select_q <= pwdata[CTL_SRC_BIT];
        end
      end else if (range_zero(multiplier_programming_reg_q)) begin
        base_source_select_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Bandwidth and programming registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      auto_q <= BW_RESET[BW_AUTO_BIT];
      xld_q <= BW_RESET[BW_XLD_BIT];
      multiplier_programming_reg_q <= MULT_RANGE_RESET;
    end else if (clk_en_i) begin
      if (bw_wr) begin
        auto_q <= pwdata[BW_AUTO_BIT];
        xld_q <= pwdata[BW_XLD_BIT];
      end
      // N upper nibble, L lower nibble
      if (mult_wr) begin
        multiplier_programming_reg_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // APB read path and outputs
  // ----------------------------------------
  logic [7:0] ctl_view;
  logic [7:0] bw_view;
  logic mapped;

  assign ctl_view = CTL_UNUSED_ONES
                  | (8'(settle_change_irq_enable_q) << CTL_IRQ_EN_BIT)
                  | (8'(settle_change_flag_q) << CTL_FLAG_BIT)
                  | (8'(loop_power_on_q) << CTL_PWR_BIT)
                  | (8'(base_source_select_q) << CTL_SRC_BIT);
  assign bw_view = (8'(auto_q) << BW_AUTO_BIT)
                 | (8'(settled_q) << BW_LOCK_BIT)
                 | (8'(track_q) << BW_TRACK_BIT)
                 | (8'(xld_q) << BW_XLD_BIT);
  // Unmapped addresses answer with pslverr; writes there are dropped
  assign mapped = hit(paddr, ADDR_LOOP_CONTROL) || hit(paddr, ADDR_BANDWIDTH) || hit(paddr, ADDR_MULT_RANGE);

  // Zero-wait-state slave: pready in the first penable cycle, right after setup
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en_i) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_LOOP_CONTROL: prdata <= {24'h00_0000, ctl_view};
          ADDR_BANDWIDTH: prdata <= {24'h00_0000, bw_view};
          ADDR_MULT_RANGE: prdata <= {24'h00_0000, multiplier_programming_reg_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vco_feedback_clock_o <= 1'b0;
      tracking_mode_o <= 1'b0;
      loop_enable_o <= 1'b0;
      base_source_select_o <= 1'b0;
      vco_range_o <= 4'h0;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      vco_feedback_clock_o <= fb_tick;
      // acquisition shows cleared flag; tracking otherwise
      tracking_mode_o <= track_q;
      loop_enable_o <= loop_run;
      base_source_select_o <= base_source_select_q;
      vco_range_o <= multiplier_programming_reg_q[3:0];
      irq_o <= auto_q && settle_change_irq_enable_q && settle_change_flag_q;
    end
  end
endmodule // pll_mode_lock_control

//--- test/pll_mode_lock_control_asserts.sv
// Concurrent checks on the loop control block ports
`timescale 1ns/1ps
module pll_mode_lock_control_asserts
  import pll_ctl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Loop
  input wire logic final_reference_clock_i,
  input wire logic vco_feedback_clock_o,
  input wire logic pump_up_o,
  input wire logic pump_down_o,
  input wire logic loop_enable_o,
  input wire logic base_source_select_o,
  input wire logic [3:0] vco_range_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_ACK_NEXT: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_ACK_PULSE: assert property (pready |=> !pready)
    else $error("pready held over two cycles");
  AST_ERR_WITH_ACK: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an access");
  AST_RANGE_ZERO: assert property (vco_range_o == 4'h0 |-> !loop_enable_o ##1 !base_source_select_o)
    else $error("loop running with zero range");
  AST_SRC_NEEDS_PWR: assert property ($rose(base_source_select_o) |-> loop_enable_o)
    else $error("source selected while loop off");
  AST_PWR_HOLD: assert property (base_source_select_o && $fell(loop_enable_o) |-> vco_range_o == 4'h0)
    else $error("loop switched off while selected");
  AST_FB_OFF: assert property (!loop_enable_o [*2] |=> !vco_feedback_clock_o)
    else $error("feedback pulse with loop off");
  AST_PUMP_EXCL: assert property (!(pump_up_o && pump_down_o))
    else $error("both pump directions active");
  AST_PUMP_UP_CAUSE: assert property ($rose(pump_up_o) |-> $past(final_reference_clock_i))
    else $error("pump up without reference edge");
  AST_IRQ_CLEAR: assert property (pready && !pwrite && !pslverr && paddr == ADDR_LOOP_CONTROL |=> ##[0:1] !irq_o)
    else $error("irq kept after control read");
  COV_IRQ: cover property ($rose(irq_o));
  COV_ERR: cover property (pslverr);
  COV_SRC: cover property ($rose(base_source_select_o));
endmodule // pll_mode_lock_control_asserts

bind pll_mode_lock_control pll_mode_lock_control_asserts u_asserts (.core_clk_i, .reset_n_i, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .final_reference_clock_i, .vco_feedback_clock_o, .pump_up_o, .pump_down_o,
  .loop_enable_o, .base_source_select_o, .vco_range_o, .irq_o);

//--- test/pll_mode_lock_control_tb.sv
// Self-checking bench for the loop control block
`timescale 1ns/1ps
module pll_mode_lock_control_tb;
  import pll_ctl_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic vco_clock_i = 1'b0;
  logic final_reference_clock_i = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, vco_feedback_clock_o, pump_up_o, pump_down_o;
  logic tracking_mode_o, loop_enable_o, base_source_select_o, irq_o;
  logic [3:0] vco_range_o;
  logic vco_on = 1'b0;
  int seed = 79;
  int err_total = 0;
  int check_count = 0;
  int fb_cnt = 0;
  int cyc_n = 0;
  int ref_per = 0;
  // Register model
  int pwr_m = 1;
  int src_m = 0;
  int ie_m = 0;
  int auto_m = 0;
  int l_m = 6;
  int flag_m = 0;
  byte unsigned cq[$] = '{8'h30, 8'h10, 8'h00, 8'h00, 8'h10, 8'h30, 8'h20, 8'h30};

  pll_mode_lock_control DUT (.core_clk_i, .reset_n_i, .clk_en_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .vco_clock_i, .final_reference_clock_i, .vco_feedback_clock_o, .pump_up_o,
    .pump_down_o, .tracking_mode_o, .loop_enable_o, .base_source_select_o, .vco_range_o, .irq_o);

  always #10 core_clk_i = ~core_clk_i;

  // Strobe sources and feedback pulse counter
  always @(posedge core_clk_i) begin
    cyc_n <= cyc_n + 1;
    vco_clock_i <= vco_on;
    final_reference_clock_i <= (ref_per != 0) && (cyc_n % ref_per == 0);
    if (vco_feedback_clock_o === 1'b1) begin
      fb_cnt <= fb_cnt + 1;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      chk("pready", 1, pready);
      end_sim();
    end
    @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", x, r);
    if (a == ADDR_LOOP_CONTROL) begin
      flag_m = 0;
    end
  endtask

  // Select refusal uses the power state from before the write
  task automatic wctl(input logic [7:0] d);
    int s;
    s = d[4] && pwr_m == 1 && l_m != 0;
    pwr_m = (src_m == 1 && !d[5]) ? 1 : d[5];
    src_m = s;
    ie_m = auto_m ? d[7] : 0;
    wr(ADDR_LOOP_CONTROL, {24'h00_0000, d});
  endtask

  function automatic logic [31:0] ctl_exp();
    return {24'h00_0000, ie_m[0], flag_m[0], pwr_m[0], src_m[0], 4'hF};
  endfunction

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq_o !== 1'b1 && k < 600) begin
      @(posedge core_clk_i);
      k++;
    end
    if (k >= 600) begin
      chk("irq_o", 1, irq_o);
      end_sim();
    end
    flag_m = 1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    int s;
    int x;
    cyc(6);
    reset_n_i <= 1'b1;
    rd(ADDR_LOOP_CONTROL, CTL_RESET);
    rd(ADDR_BANDWIDTH, BW_RESET);
    rd(ADDR_MULT_RANGE, MULT_RANGE_RESET);
    apb(1'b1, 8'h0C, $random(seed), r, e);
    chk("pslverr", 1, e);
    apb(1'b0, 8'h0C, 32'h0000_0000, r, e);
    chk("pslverr", 1, e);
    chk("prdata", 0, r);
    x = $random(seed);
    wr(ADDR_MULT_RANGE, x);
    rd(ADDR_MULT_RANGE, x & 32'h0000_00FF);
    // Divider: eight pulses per eight multiplier periods
    vco_on <= 1'b1;
    for (int n = 0; n < 16; n++) begin
      wr(ADDR_MULT_RANGE, {n[3:0], 4'h6});
      cyc(40);
      chk("vco_range_o", 6, vco_range_o);
      s = fb_cnt;
      cyc(8 * ((n == 0) ? 1 : n));
      chk("fb_pulses", 8, fb_cnt - s);
    end
    // Frozen clock enable holds every register, divider included
    clk_en_i <= 1'b0;
    cyc(1);
    x = vco_feedback_clock_o;
    s = fb_cnt;
    cyc(20);
    chk("vco_feedback_clock_o", x, vco_feedback_clock_o);
    chk("fb_pulses", (x == 1) ? 20 : 0, fb_cnt - s);
    clk_en_i <= 1'b1;
    // Manual mode
    // loop on since reset, well past acquisition
    x = {$random(seed)} % 2;
    wr(ADDR_BANDWIDTH, 32'h0000_0020 | (x << 4));
    rd(ADDR_BANDWIDTH, 32'h0000_0020 | (x << 4));
    cyc(2);
    chk("tracking_mode_o", 1, tracking_mode_o);
    // settle in tracking before selecting the VCO
    cyc(20);
    wctl(8'h30);
    cyc(2);
    chk("base_source_select_o", src_m, base_source_select_o);
    wctl(8'h20);
    wr(ADDR_BANDWIDTH, 32'h0000_0000);
    cyc(2);
    chk("tracking_mode_o", 0, tracking_mode_o);
    wctl(8'hA0);
    rd(ADDR_LOOP_CONTROL, ctl_exp());
    chk("irq_o", 0, irq_o);
    // tracking flag stays clear for every power-on below
    foreach (cq[i]) begin
      wctl(cq[i]);
      rd(ADDR_LOOP_CONTROL, ctl_exp());
      cyc(2);
      chk("base_source_select_o", src_m, base_source_select_o);
      chk("loop_enable_o", pwr_m == 1 && l_m != 0, loop_enable_o);
    end
    // Zero range while the VCO is selected
    wr(ADDR_MULT_RANGE, 32'h0000_0040);
    l_m = 0;
    src_m = 0;
    cyc(2);
    chk("loop_enable_o", 0, loop_enable_o);
    chk("base_source_select_o", 0, base_source_select_o);
    wctl(8'h30);
    rd(ADDR_LOOP_CONTROL, ctl_exp());
    wctl(8'h20);
    wr(ADDR_MULT_RANGE, 32'h0000_0046);
    l_m = 6;
    // Automatic mode: lock then loss of lock
    wr(ADDR_BANDWIDTH, 32'h0000_0080);
    auto_m = 1;
    wctl(8'hA0);
    ref_per <= 4;
    wait_irq();
    rd(ADDR_BANDWIDTH, 32'h0000_00E0);
    chk("tracking_mode_o", 1, tracking_mode_o);
    rd(ADDR_LOOP_CONTROL, ctl_exp());
    cyc(3);
    chk("irq_o", 0, irq_o);
    rd(ADDR_LOOP_CONTROL, ctl_exp());
    wctl(8'hB0);
    ref_per <= 8;
    wait_irq();
    rd(ADDR_BANDWIDTH, 32'h0000_0080);
    chk("tracking_mode_o", 0, tracking_mode_o);
    rd(ADDR_LOOP_CONTROL, ctl_exp());
    chk("base_source_select_o", src_m, base_source_select_o);
    end_sim();
  end
endmodule // pll_mode_lock_control_tb
